// file: adcctl_top.v
// Converter control: AHB-Lite registers, conversion sequencer, result and interrupt
//
// Added by the designer: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`include "adcctl_regs.vh"
module adcctl_top (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hready,
    input wire [31:0] hwdata,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire comp_in,
    input wire gint_en,
    output wire adc_on,
    output wire [3:0] chan_sel,
    output wire int_src_sel,
    output wire [2:0] ref_sel,
    output wire sampling,
    output wire [11:0] dac_code,
    output wire [10:0] dig_in_en,
    output wire irq
);
    localparam ST_IDLE = 4'b0001;
    localparam ST_SAMPLE = 4'b0010;
    localparam ST_CONV = 4'b0100;
    localparam ST_TAIL = 4'b1000;

    // Address phase captured for the data phase
    reg dp_valid;
    reg dp_write;
    reg [7:0] dp_addr;

    // Software-visible state
    reg en_reg;
    reg [3:0] ch_reg;
    reg [2:0] res_code;
    reg [2:0] div_sel;
    reg [2:0] ref_reg;
    reg int_src_reg;
    reg [11:0] result;
    reg irq_req;
    reg irq_en;
    reg [10:0] dier;

    // Sequencer
    reg [3:0] state;
    reg [3:0] bit_idx;
    reg [11:0] trial;
    reg [2:0] tail_cnt;

    // Comparator synchroniser
    reg comp_s1;
    reg comp_s2;
    reg comp_s3;
    reg comp_q;

    wire wr_en;
    wire busy;
    wire tick;
    wire ctrl_wr;
    wire start_req;
    wire abort;
    wire done;
    wire irq_clr;
    wire [3:0] lsb_idx;
    wire [11:0] kept;

    function hit;
        input [7:0] addr;
        input [7:0] off;
        begin
            hit = (addr == off);
        end
    endfunction

    function [11:0] bit_mask;
        input [3:0] idx;
        begin
            bit_mask = 12'h001 << idx;
        end
    endfunction

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wr_en = dp_valid & dp_write;
    assign busy = (state != ST_IDLE);
    assign ctrl_wr = wr_en & hit(dp_addr, `ADCCTL_OFF_CTRL);
    // Enable and go may be written together; start needs the new enable
    assign start_req = ctrl_wr & hwdata[`ADCCTL_CTRL_GO_BIT] & hwdata[`ADCCTL_CTRL_EN_BIT] & ~busy;
    assign abort = busy & ctrl_wr & ~hwdata[`ADCCTL_CTRL_EN_BIT];
    assign done = (state == ST_TAIL) & tick & (tail_cnt == `ADCCTL_TAIL_PERIODS - 3'h1);
    assign irq_clr = wr_en & hit(dp_addr, `ADCCTL_OFF_IRQ_REQ) & hwdata[`ADCCTL_IRQ_BIT];
    // Codes above twelve bits act as twelve
    assign lsb_idx = (res_code >= `ADCCTL_RES_CODE_MAX) ? 4'h0 : {1'b0, `ADCCTL_RES_CODE_MAX - res_code};
    assign kept = comp_q ? trial : (trial & ~bit_mask(bit_idx));

    assign adc_on = en_reg;
    assign chan_sel = ch_reg;
    assign int_src_sel = int_src_reg;
    assign ref_sel = ref_reg;
    assign sampling = (state == ST_SAMPLE);
    assign dac_code = trial;
    assign dig_in_en = dier;
    assign irq = irq_req & irq_en & gint_en;

    adcctl_tick u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear(~busy),
        .div_sel(div_sel),
        .tick(tick)
    );

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
        end else if (hready) begin
            dp_valid <= hsel & htrans[1];
            dp_write <= hwrite;
            dp_addr <= haddr[7:0];
        end
    end

    // Comparator is asynchronous; it must settle four clocks before each tick
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            comp_s1 <= 1'b0;
            comp_s2 <= 1'b0;
            comp_s3 <= 1'b0;
            comp_q <= 1'b0;
        end else begin
            comp_s1 <= comp_in;
            comp_s2 <= comp_s1;
            comp_s3 <= comp_s2;
            if (comp_s2 == comp_s3) begin
                comp_q <= comp_s3;
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_reg <= 1'b0;
            ch_reg <= `ADCCTL_RST_CH;
            res_code <= `ADCCTL_RST_RES;
            div_sel <= `ADCCTL_RST_DIV;
            ref_reg <= `ADCCTL_RST_REF;
            int_src_reg <= 1'b0;
            irq_en <= 1'b0;
            dier <= `ADCCTL_RST_DIER;
        end else if (wr_en) begin
            if (hit(dp_addr, `ADCCTL_OFF_CTRL)) begin
                en_reg <= hwdata[`ADCCTL_CTRL_EN_BIT];
                ch_reg <= hwdata[`ADCCTL_CTRL_CH_HI:`ADCCTL_CTRL_CH_LO];
            end
            if (hit(dp_addr, `ADCCTL_OFF_MODE)) begin
                res_code <= hwdata[`ADCCTL_MODE_RES_HI:`ADCCTL_MODE_RES_LO];
                div_sel <= hwdata[`ADCCTL_MODE_DIV_HI:`ADCCTL_MODE_DIV_LO];
            end
            if (hit(dp_addr, `ADCCTL_OFF_REF)) begin
                ref_reg <= hwdata[`ADCCTL_REF_SEL_HI:`ADCCTL_REF_SEL_LO];
                int_src_reg <= hwdata[`ADCCTL_REF_INT_BIT];
            end
            if (hit(dp_addr, `ADCCTL_OFF_IRQ_EN)) begin
                irq_en <= hwdata[`ADCCTL_IRQ_BIT];
            end
            if (hit(dp_addr, `ADCCTL_OFF_DIER)) begin
                dier <= hwdata[10:0];
            end
        end
    end

    // Completion wins over a clear in the same cycle
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_req <= 1'b0;
        end else begin
            irq_req <= (irq_req & ~irq_clr) | done;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result <= 12'h000;
        end else if (done) begin
            result <= trial;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_IDLE;
            bit_idx <= `ADCCTL_MSB_IDX;
            trial <= 12'h000;
            tail_cnt <= 3'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start_req) begin
                        state <= ST_SAMPLE;
                        trial <= 12'h000;
                    end
                end
                ST_SAMPLE: begin
                    if (abort) begin
                        state <= ST_IDLE;
                    end else if (tick) begin
                        state <= ST_CONV;
                        bit_idx <= `ADCCTL_MSB_IDX;
                        trial <= bit_mask(`ADCCTL_MSB_IDX);
                    end
                end
                ST_CONV: begin
                    if (abort) begin
                        state <= ST_IDLE;
                    end else if (tick) begin
                        if (bit_idx == lsb_idx) begin
                            state <= ST_TAIL;
                            trial <= kept;
                            tail_cnt <= 3'h0;
                        end else begin
                            trial <= kept | bit_mask(bit_idx - 4'h1);
                            bit_idx <= bit_idx - 4'h1;
                        end
                    end
                end
                ST_TAIL: begin
                    if (abort) begin
                        state <= ST_IDLE;
                    end else if (tick) begin
                        tail_cnt <= tail_cnt + 3'h1;
                        if (done) begin
                            state <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Read data from the latched address; go/done reads one when idle
    always @* begin
        hrdata = 32'h00000000;
        if (dp_valid && !dp_write) begin
            case (dp_addr)
                `ADCCTL_OFF_CTRL: begin
                    hrdata[`ADCCTL_CTRL_EN_BIT] = en_reg;
                    hrdata[`ADCCTL_CTRL_GO_BIT] = ~busy;
                    hrdata[`ADCCTL_CTRL_CH_HI:`ADCCTL_CTRL_CH_LO] = ch_reg;
                end
                `ADCCTL_OFF_MODE: begin
                    hrdata[`ADCCTL_MODE_RES_HI:`ADCCTL_MODE_RES_LO] = res_code;
                    hrdata[`ADCCTL_MODE_DIV_HI:`ADCCTL_MODE_DIV_LO] = div_sel;
                end
                `ADCCTL_OFF_REF: begin
                    hrdata[`ADCCTL_REF_SEL_HI:`ADCCTL_REF_SEL_LO] = ref_reg;
                    hrdata[`ADCCTL_REF_INT_BIT] = int_src_reg;
                end
                `ADCCTL_OFF_RESH: begin
                    hrdata[7:0] = result[11:4];
                end
                `ADCCTL_OFF_RESL: begin
                    hrdata[7:4] = result[3:0];
                end
                `ADCCTL_OFF_IRQ_REQ: begin
                    hrdata[`ADCCTL_IRQ_BIT] = irq_req;
                end
                `ADCCTL_OFF_IRQ_EN: begin
                    hrdata[`ADCCTL_IRQ_BIT] = irq_en;
                end
                `ADCCTL_OFF_DIER: begin
                    hrdata[10:0] = dier;
                end
                default: begin
                    hrdata = 32'h00000000;
                end
            endcase
        end
    end
endmodule

// file: adcctl_regs.vh
// Register map, field positions and timing counts of the converter control block
`ifndef ADCCTL_REGS_VH
`define ADCCTL_REGS_VH

`define ADCCTL_OFF_CTRL 8'h00
`define ADCCTL_OFF_MODE 8'h04
`define ADCCTL_OFF_REF 8'h08
`define ADCCTL_OFF_RESH 8'h0C
`define ADCCTL_OFF_RESL 8'h10
`define ADCCTL_OFF_IRQ_REQ 8'h14
`define ADCCTL_OFF_IRQ_EN 8'h18
`define ADCCTL_OFF_DIER 8'h1C

`define ADCCTL_CTRL_EN_BIT 7
`define ADCCTL_CTRL_GO_BIT 6
`define ADCCTL_CTRL_CH_HI 3
`define ADCCTL_CTRL_CH_LO 0
`define ADCCTL_MODE_RES_HI 6
`define ADCCTL_MODE_RES_LO 4
`define ADCCTL_MODE_DIV_HI 2
`define ADCCTL_MODE_DIV_LO 0
`define ADCCTL_REF_SEL_HI 7
`define ADCCTL_REF_SEL_LO 5
`define ADCCTL_REF_INT_BIT 0
`define ADCCTL_IRQ_BIT 3

`define ADCCTL_RST_CH 4'h0
`define ADCCTL_RST_RES 3'h0
`define ADCCTL_RST_DIV 3'h0
`define ADCCTL_RST_REF 3'h0
`define ADCCTL_RST_DIER 11'h7FF

`define ADCCTL_RES_CODE_MAX 3'h4
`define ADCCTL_MSB_IDX 4'hB
`define ADCCTL_TAIL_PERIODS 3'h4

`endif

// file: adcctl_tick.v
// Conversion clock divider: one-cycle tick every 2^div_sel system clocks
`timescale 1ns/1ps
module adcctl_tick (
    input wire hclk,
    input wire hresetn,
    input wire clear,
    input wire [2:0] div_sel,
    output wire tick
);
    reg [6:0] cnt;
    wire [6:0] limit;

    // All ones below bit div_sel, so the period is 2^div_sel cycles
    assign limit = ~(7'h7F << div_sel);
    assign tick = ~clear & (cnt == limit);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 7'h00;
        end else if (clear || tick) begin
            cnt <= 7'h00;
        end else begin
            cnt <= cnt + 7'h01;
        end
    end
endmodule

// file: adcctl_src.sv
// Analog input and comparator model at the converter's far side
`timescale 1ns/1ps
module adcctl_src (
    input wire hclk,
    input wire adc_on,
    input wire [3:0] chan_sel,
    input wire [11:0] dac_code,
    output wire comp_in
);
    reg alt = 1'b0;
    wire [11:0] lvl = {chan_sel, 8'h3C} + 12'h123;
    // Unpowered comparator wanders instead of holding its last value
    always @(posedge hclk) begin
        if (!adc_on) begin
            alt <= ~alt;
        end
    end
    assign comp_in = adc_on ? (lvl >= dac_code) : alt;
endmodule

// file: adcctl_chk_asserts.sv
// Port-level assertions for the converter control block
`timescale 1ns/1ps
module adcctl_chk (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hwdata,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire gint_en,
    input wire irq,
    input wire adc_on,
    input wire [3:0] chan_sel,
    input wire int_src_sel,
    input wire [2:0] ref_sel,
    input wire sampling,
    input wire [11:0] dac_code,
    input wire [10:0] dig_in_en
);
    reg dwr;
    reg drd;
    reg go_q;
    reg [7:0] da;
    reg [7:0] scnt;
    reg [2:0] div;
    reg [31:0] lwd;
    wire go_wr = dwr && da == 8'h00 && hwdata[7] && hwdata[6];
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dwr <= 1'b0;
            drd <= 1'b0;
            go_q <= 1'b0;
            da <= 8'h00;
            scnt <= 8'h00;
            div <= 3'h0;
            lwd <= 32'h0;
        end else begin
            if (hready) begin
                dwr <= hsel && htrans[1] && hwrite;
                drd <= hsel && htrans[1] && !hwrite;
                da <= haddr[7:0];
            end
            if (dwr && da == 8'h04) begin
                div <= hwdata[2:0];
            end
            go_q <= go_wr;
            lwd <= hwdata;
            scnt <= sampling ? scnt + 8'h01 : 8'h00;
        end
    end
    chk_gint_gate: assert property (!gint_en |-> !irq)
        else $error("irq raised with global enable off");
    chk_samp_on: assert property (sampling |-> adc_on)
        else $error("sampling while disabled");
    chk_samp_len: assert property ($fell(sampling) && adc_on |-> scnt == (8'h01 << div))
        else $error("sample window length wrong");
    chk_msb_first: assert property ($fell(sampling) && adc_on |-> dac_code[11])
        else $error("first trial is not the top bit");
    chk_start_src: assert property ($rose(sampling) |-> go_q)
        else $error("conversion began without a start write");
    chk_ctrl_wr: assert property (dwr && da == 8'h00 |=> chan_sel == lwd[3:0] && adc_on == lwd[7])
        else $error("control write not applied");
    chk_ref_wr: assert property (dwr && da == 8'h08 |=> ref_sel == lwd[7:5] && int_src_sel == lwd[0])
        else $error("reference write not applied");
    chk_dier_wr: assert property (dwr && da == 8'h1C |=> dig_in_en == lwd[10:0])
        else $error("input enable write not applied");
    chk_rd_idle: assert property (!drd |-> hrdata == 32'h0)
        else $error("read data outside a read");
    chk_resp_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready and okay");
endmodule
bind adcctl_top adcctl_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .hrdata,
    .gint_en, .irq, .adc_on, .chan_sel, .int_src_sel, .ref_sel, .sampling, .dac_code, .dig_in_en,
    .hreadyout, .hresp);

// file: adcctl_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module testbench;
    reg hclk = 1'b0;
    reg hresetn = 1'b0;
    reg hsel = 1'b0;
    reg hwrite = 1'b0;
    reg gint_en = 1'b0;
    reg [1:0] htrans = 2'h0;
    reg [31:0] haddr = 32'h0;
    reg [31:0] hwdata = 32'h0;
    reg [31:0] q;
    reg [11:0] e;
    reg [3:0] ch;
    reg [2:0] dv;
    wire [31:0] hrdata;
    wire hreadyout, hresp, comp_in, adc_on, int_src_sel, sampling, irq;
    wire [3:0] chan_sel;
    wire [2:0] ref_sel;
    wire [11:0] dac_code;
    wire [10:0] dig_in_en;
    integer n_mismatch = 0;
    integer check_count = 0;
    integer cyc = 0;
    integer r;
    integer k;
    integer n;
    adcctl_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .comp_in(comp_in), .gint_en(gint_en), .adc_on(adc_on),
        .chan_sel(chan_sel), .int_src_sel(int_src_sel), .ref_sel(ref_sel), .sampling(sampling),
        .dac_code(dac_code), .dig_in_en(dig_in_en), .irq(irq));
    adcctl_src u_src (.hclk(hclk), .adc_on(adc_on), .chan_sel(chan_sel), .dac_code(dac_code), .comp_in(comp_in));
    initial begin
        forever #25 hclk = ~hclk;
    end
    task end_sim;
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            end_sim;
        end
    end
    task chk(input string nm, input [31:0] got, input [31:0] x);
        check_count = check_count + 1;
        if (got !== x) begin
            n_mismatch = n_mismatch + 1;
            $display("BAD %s expected %h seen %h", nm, x, got);
        end
    endtask
    task bus(input [7:0] a, input w, input [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            @(posedge hclk);
        end
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            @(posedge hclk);
        end
        q = hrdata;
    endtask
    task rd(input string nm, input [7:0] a, input [31:0] x);
        bus(a, 1'b0, 32'h0);
        chk(nm, q, x);
    endtask
    // Sampling, bit trials and tail periods are timed from the start edge to the request
    task conv;
        ch = 4'(11 - 2 * r);
        dv = 3'(3 + r % 2);
        // Codes above four convert as twelve bits
        n = (r > 4) ? 4 : r;
        e = ({ch, 8'h3C} + 12'h123) & (12'hFFF << (4 - n));
        bus(8'h14, 1'b1, 32'h8);
        bus(8'h04, 1'b1, {25'h0, 3'(r), 1'b0, dv});
        bus(8'h00, 1'b1, {24'h0, 4'hC, ch});
        k = 0;
        while (irq !== 1'b1 && k < 400) begin
            @(negedge hclk);
            k = k + 1;
            if (k == 1) begin
                chk("chan", chan_sel, ch);
            end
            if (k == 10) begin
                rd("busy", 8'h00, {24'h0, 4'h8, ch});
                k = k + 2;
            end
            if (k == 30) begin
                bus(8'h00, 1'b1, {24'h0, 4'hC, ch});
                k = k + 2;
            end
        end
        // Loop leaves on the first falling edge after the completion edge
        chk("time", k, ((13 + n) << dv) + 1);
        rd("res_hi", 8'h0C, e[11:4]);
        rd("res_lo", 8'h10, {e[3:0], 4'h0});
        rd("done", 8'h00, {24'h0, 4'hC, ch});
    endtask
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rd("ctrl", 8'h00, 32'h40);
        rd("dier", 8'h1C, 32'h7FF);
        rd("unmapped", 8'h40, 32'h0);
        bus(8'h1C, 1'b1, 32'h555);
        // Write lands at the edge that ends the task
        @(negedge hclk);
        chk("dig_in", dig_in_en, 32'h555);
        for (r = 0; r < 8; r = r + 1) begin
            bus(8'h08, 1'b1, {24'h0, 3'(r), 5'h01});
            rd("ref", 8'h08, {24'h0, 3'(r), 5'h01});
            chk("ref_sel", ref_sel, r);
        end
        chk("int_src", int_src_sel, 32'h1);
        bus(8'h18, 1'b1, 32'h8);
        gint_en <= 1'b1;
        for (r = 0; r < 6; r = r + 1) begin
            conv;
        end
        chk("irq_on", irq, 32'h1);
        bus(8'h18, 1'b1, 32'h0);
        @(negedge hclk);
        chk("irq_masked", irq, 32'h0);
        @(posedge hclk);
        gint_en <= 1'b0;
        bus(8'h18, 1'b1, 32'h8);
        @(negedge hclk);
        chk("irq_global", irq, 32'h0);
        @(posedge hclk);
        gint_en <= 1'b1;
        bus(8'h14, 1'b1, 32'h0);
        rd("req_kept", 8'h14, 32'h8);
        bus(8'h14, 1'b1, 32'h8);
        rd("req_clr", 8'h14, 32'h0);
        chk("irq_clr", irq, 32'h0);
        bus(8'h00, 1'b1, 32'hC3);
        repeat (30) @(posedge hclk);
        bus(8'h00, 1'b1, 32'h0);
        rd("abort", 8'h00, 32'h40);
        chk("off", adc_on, 32'h0);
        rd("held", 8'h0C, e[11:4]);
        rd("no_req", 8'h14, 32'h0);
        end_sim;
    end
endmodule
